// *** hdl/diag_telegram_pkg.sv ***
`default_nettype none
package diag_telegram_pkg;
    localparam int unsigned TEL_LEN = 29;
    localparam logic [4:0] LAST_IDX = 5'h1c;
    localparam logic [4:0] IDX_ADDR = 5'h03;
    localparam logic [4:0] IDX_VEND_HI = 5'h04;
    localparam logic [4:0] IDX_VEND_LO = 5'h05;
    localparam logic [4:0] IDX_ID_HDR = 5'h06;
    localparam logic [4:0] IDX_SLOT = 5'h07;
    localparam logic [4:0] IDX_ID_END = 5'h08;
    localparam logic [4:0] IDX_DEV_LEN = 5'h09;
    localparam logic [4:0] IDX_DEV0 = 5'h0a;
    localparam logic [4:0] IDX_FAULT0 = 5'h15;
    localparam logic [7:0] ID_HDR_VAL = 8'h43;
    localparam logic [7:0] ID_END_VAL = 8'h00;
    localparam logic [7:0] DEV_LEN_VAL = 8'h14;
    localparam logic [7:0] ADDR_NONE = 8'hff;
    localparam logic [7:0] ADDR_MAX = 8'h7e;
    // vendor code value is arbitrary
    localparam logic [15:0] VENDOR_CODE = 16'h1234;
    // register offsets (byte addresses)
    localparam logic [7:0] REG_STAT0 = 8'h00;
    localparam logic [7:0] REG_STAT1 = 8'h04;
    localparam logic [7:0] REG_MASTER = 8'h08;
    localparam logic [7:0] REG_SLOT = 8'h0c;
    localparam logic [7:0] REG_FAULT_A = 8'h10;
    localparam logic [7:0] REG_FAULT_B = 8'h14;
    localparam logic [7:0] REG_DEV_LO = 8'h18;
    localparam logic [7:0] REG_CTRL = 8'h1c;
    localparam logic [7:0] REG_DEV_MID = 8'h20;
    localparam logic [7:0] REG_DEV_HI = 8'h24;
    localparam logic [7:0] STAT0_RST = 8'h02;
    localparam logic [7:0] STAT1_RST = 8'h01;
    localparam logic [7:0] STAT0_MASK = 8'hdf;
    localparam logic [7:0] STAT1_MASK = 8'h8b;
    localparam logic [7:0] SLOT_MASK = 8'h31;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01,
        TX_WAIT = 2'b11
    } tx_state_e;
endpackage : diag_telegram_pkg
`default_nettype wire

// *** hdl/diag_byte_mux.sv ***
`default_nettype none
// picks one telegram byte from the assembled image
module diag_byte_mux (
    input wire logic [4:0] idx_i,
    input wire logic [7:0] stat0_i,
    input wire logic [7:0] stat1_i,
    input wire logic [7:0] master_i,
    input wire logic [7:0] slot_i,
    input wire logic [63:0] fault_i,
    input wire logic [87:0] dev_i,
    output logic [7:0] byte_o
);
    logic [4:0] fi;
    logic [4:0] di;
    // byte select across the three telegram parts
    always_comb begin
        fi = idx_i - diag_telegram_pkg::IDX_FAULT0;
        di = idx_i - diag_telegram_pkg::IDX_DEV0;
        byte_o = 8'h00;
        if (idx_i == 5'h00) begin
            byte_o = stat0_i;
        end else if (idx_i == 5'h01) begin
            byte_o = stat1_i;
        end else if (idx_i == 5'h02) begin
            byte_o = 8'h00;
        end else if (idx_i == diag_telegram_pkg::IDX_ADDR) begin
            byte_o = master_i;
        end else if (idx_i == diag_telegram_pkg::IDX_VEND_HI) begin
            byte_o = diag_telegram_pkg::VENDOR_CODE[15:8];
        end else if (idx_i == diag_telegram_pkg::IDX_VEND_LO) begin
            byte_o = diag_telegram_pkg::VENDOR_CODE[7:0];
        end else if (idx_i == diag_telegram_pkg::IDX_ID_HDR) begin
            byte_o = diag_telegram_pkg::ID_HDR_VAL;
        end else if (idx_i == diag_telegram_pkg::IDX_SLOT) begin
            byte_o = slot_i;
        end else if (idx_i == diag_telegram_pkg::IDX_ID_END) begin
            byte_o = diag_telegram_pkg::ID_END_VAL;
        end else if (idx_i == diag_telegram_pkg::IDX_DEV_LEN) begin
            byte_o = diag_telegram_pkg::DEV_LEN_VAL;
        end else if (idx_i >= diag_telegram_pkg::IDX_FAULT0) begin
            byte_o = fault_i[fi[2:0]*8 +: 8];
        end else begin
            byte_o = dev_i[di[3:0]*8 +: 8];
        end
    end
endmodule : diag_byte_mux
`default_nettype wire

// *** hdl/diag_telegram.sv ***
`default_nettype none
// diagnosis telegram framer with wishbone register access
//
// register map, byte offsets
//   00 station status byte 0, read only, bit 5 always zero
//   04 station status byte 1: write bit 0 parameter request, bit 1 static diag
//   08 parameterizing master address; values above 7eh are kept as ffh
//   0c slot byte of the identifier part, read only
//   10 slave fault bytes 21 to 24, read only
//   14 slave fault bytes 25 to 28, read only
//   18 device bytes 10 to 13, byte lanes by select
//   1c spare control byte
//   20 device bytes 14 to 17, byte lanes by select
//   24 device bytes 18 to 20, byte lanes by select
//   other offsets read zero and ignore writes, but are still acked
//
// bus timing
//   request taken at the edge with cyc, stb and no ack
//   ack and read data follow one cycle later, ack for one cycle only
//   the master must drop cyc and stb after it sees ack
//
// telegram stream
//   start is taken only while idle, later starts are ignored
//   first byte is offered two cycles after start
//   each byte stands with valid until an edge with ready
//   one idle cycle follows each accepted byte while the next is loaded
//   last marks byte 28; busy falls after it is taken
//
// after reset
//   ack, read data and stream outputs low, frame idle
//   master address ffh, parameter request set, static diag clear
//   device bytes and spare byte clear
//   a request may come at the first edge after reset falls
//
// status levels feed the status bytes directly, so a byte shows
// the level it had one cycle before it was offered
// slave faults are frozen for the whole frame so that byte 0 bit 3
// always agrees with bytes 21 to 28 of the same telegram
module diag_telegram (
    input wire logic clk_i,
    input wire logic rst_i,

    // wishbone slave, classic single cycle
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,

    // gateway status inputs, levels
    input wire logic unreachable_i,
    input wire logic not_ready_i,
    input wire logic cfg_fault_i,
    input wire logic unsupported_fn_i,
    input wire logic prm_fault_i,
    input wire logic deactivated_i,
    input wire logic monitor_active_i,

    // access by the programming_device or a foreign master, slot diagnosis and per-slave faults
    input wire logic foreign_access_i,
    input wire logic programming_device_i,
    input wire logic safety_slot_diag_i,
    input wire logic std_slot_diag_i,
    input wire logic [63:0] slave_fault_i,

    // telegram byte stream
    input wire logic tx_start_i,
    input wire logic tx_ready_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic tx_last_o,
    output logic tx_busy_o
);

    // sender state and byte index
    diag_telegram_pkg::tx_state_e state_r;
    logic [4:0] idx_r;

    // software visible state
    logic [7:0] master_r;
    logic prm_req_r;
    logic static_diag_r;
    logic [7:0] ctrl_r;

    // device-related bytes, one register per byte, and their packed view
    logic [7:0] dev_bytes [0:10];
    logic [87:0] dev_r;

    // slave fault snapshot
    logic [63:0] fault_r;

    // assembled status and slot bytes
    logic [7:0] stat0;
    logic [7:0] stat1;
    logic [7:0] slot;
    logic [7:0] mux_byte;

    // bus request decode
    logic wb_req;
    logic wb_wr;
    logic [7:0] w0;

    // a request counts once: the cycle that carries ack is not a new one
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // byte-wide registers need the low lane selected
    assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
    assign w0 = wb_dat_i[7:0];

    // station status byte 0, positive error polarity
    always_comb begin
        stat0 = 8'h00;
        stat0[0] = unreachable_i;
        stat0[1] = not_ready_i;
        stat0[2] = cfg_fault_i;
        stat0[3] = |fault_r;
        stat0[4] = unsupported_fn_i;
        stat0[5] = 1'b0; // filled in by the master
        stat0[6] = prm_fault_i;
        stat0[7] = foreign_access_i | programming_device_i;
    end

    // station status byte 1, reserved bits 2 and 4-6 zero
    always_comb begin
        stat1 = 8'h00;
        stat1[0] = prm_req_r;
        stat1[1] = static_diag_r;
        stat1[3] = monitor_active_i;
        stat1[7] = deactivated_i;
    end

    // slot bits of the identifier part, fixed bits zero
    always_comb begin
        slot = 8'h00;
        slot[4] = safety_slot_diag_i;
        slot[5] = std_slot_diag_i;
        slot[0] = safety_slot_diag_i | std_slot_diag_i;
    end

    // snapshot of per-slave faults; frozen while a telegram is sent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_r <= 64'h0;
        end else if (state_r == diag_telegram_pkg::TX_IDLE) begin
            fault_r <= slave_fault_i;
        end
    end

    // parameterizing master address, ffh when none
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_r <= diag_telegram_pkg::ADDR_NONE;
        end else if (wb_wr && wb_adr_i == diag_telegram_pkg::REG_MASTER) begin
            if (w0 <= diag_telegram_pkg::ADDR_MAX) begin
                master_r <= w0;
            end else begin
                master_r <= diag_telegram_pkg::ADDR_NONE;
            end
        end
    end

    // control flags written by software; bad parameters force a new request
    // a faulty parameter level and a software clear in one cycle leave the
    // request set, so the master is always asked to parameterize again
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prm_req_r <= 1'b1;
            static_diag_r <= 1'b0;
        end else begin
            if (prm_fault_i) begin
                prm_req_r <= 1'b1; // set wins over clear
            end else if (wb_wr && wb_adr_i == diag_telegram_pkg::REG_STAT1) begin
                prm_req_r <= w0[0];
            end
            if (wb_wr && wb_adr_i == diag_telegram_pkg::REG_STAT1) begin
                static_diag_r <= w0[1];
            end
        end
    end

    // spare control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= 8'h00;
        end else if (wb_wr && wb_adr_i == diag_telegram_pkg::REG_CTRL) begin
            ctrl_r <= w0;
        end
    end

    // device-related bytes 10 to 20, four byte lanes per word offset, three at 24h
    for (genvar b = 0; b < 11; b++) begin : g_dev
        // word offset and byte lane that reach this byte
        localparam logic [7:0] WORD_ADR = (b < 4) ? diag_telegram_pkg::REG_DEV_LO :
            (b < 8) ? diag_telegram_pkg::REG_DEV_MID : diag_telegram_pkg::REG_DEV_HI;
        localparam int LANE = b % 4;

        // software write, only the selected lane
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                dev_bytes[b] <= 8'h00;
            end else if (wb_req && wb_we_i && wb_adr_i == WORD_ADR && wb_sel_i[LANE]) begin
                dev_bytes[b] <= wb_dat_i[LANE*8 +: 8];
            end
        end

        // packed view for the byte source and read back
        assign dev_r[b*8 +: 8] = dev_bytes[b];
    end

    // bus ack one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // read data, unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (wb_req) begin
            unique case (wb_adr_i)
                diag_telegram_pkg::REG_STAT0: begin
                    wb_dat_o <= {24'h0, stat0};
                end
                diag_telegram_pkg::REG_STAT1: begin
                    wb_dat_o <= {24'h0, stat1};
                end
                diag_telegram_pkg::REG_MASTER: begin
                    wb_dat_o <= {24'h0, master_r};
                end
                diag_telegram_pkg::REG_SLOT: begin
                    wb_dat_o <= {24'h0, slot};
                end
                diag_telegram_pkg::REG_FAULT_A: begin
                    wb_dat_o <= fault_r[31:0];
                end
                diag_telegram_pkg::REG_FAULT_B: begin
                    wb_dat_o <= fault_r[63:32];
                end
                diag_telegram_pkg::REG_DEV_LO: begin
                    wb_dat_o <= dev_r[31:0];
                end
                diag_telegram_pkg::REG_CTRL: begin
                    wb_dat_o <= {24'h0, ctrl_r};
                end
                diag_telegram_pkg::REG_DEV_MID: begin
                    wb_dat_o <= dev_r[63:32];
                end
                diag_telegram_pkg::REG_DEV_HI: begin
                    wb_dat_o <= {8'h0, dev_r[87:64]};
                end
                default: begin
                    wb_dat_o <= 32'h0;
                end
            endcase
        end
    end

    // telegram byte source
    diag_byte_mux u_mux (
        .idx_i(idx_r),
        .stat0_i(stat0),
        .stat1_i(stat1),
        .master_i(master_r),
        .slot_i(slot),
        .fault_i(fault_r),
        .dev_i(dev_r),
        .byte_o(mux_byte)
    );

    // sender: bytes leave in ascending order from byte 0
    // idle keeps the index at zero so every frame begins at byte 0
    // send loads the output byte, wait offers it until ready is seen
    // the extra send cycle per byte keeps the output byte registered
    // a start that comes while busy is dropped, not queued
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= diag_telegram_pkg::TX_IDLE;
            idx_r <= 5'h00;
        end else begin
            unique case (state_r)
                diag_telegram_pkg::TX_IDLE: begin
                    idx_r <= 5'h00;
                    if (tx_start_i) begin
                        state_r <= diag_telegram_pkg::TX_SEND;
                    end
                end

                // output byte is loaded in this cycle
                diag_telegram_pkg::TX_SEND: begin
                    state_r <= diag_telegram_pkg::TX_WAIT;
                end

                // byte on offer until the sink takes it
                diag_telegram_pkg::TX_WAIT: begin
                    if (tx_ready_i) begin
                        if (idx_r == diag_telegram_pkg::LAST_IDX) begin
                            state_r <= diag_telegram_pkg::TX_IDLE;
                        end else begin
                            idx_r <= idx_r + 5'h01;
                            state_r <= diag_telegram_pkg::TX_SEND;
                        end
                    end
                end
                default: state_r <= diag_telegram_pkg::TX_IDLE;
            endcase
        end
    end

    // registered output byte, loaded before it is offered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_data_o <= 8'h00;
            tx_last_o <= 1'b0;
        end else if (state_r == diag_telegram_pkg::TX_SEND) begin
            tx_data_o <= mux_byte;
            tx_last_o <= (idx_r == diag_telegram_pkg::LAST_IDX);
        end
    end


    // offer only in the wait state, so data and last are already settled
    assign tx_valid_o = (state_r == diag_telegram_pkg::TX_WAIT);

    // busy from the taken start to the accepted last byte
    assign tx_busy_o = (state_r != diag_telegram_pkg::TX_IDLE);
endmodule : diag_telegram
`default_nettype wire

// *** bench/diag_telegram_checker.sv ***
`default_nettype none
// watches the register handshake and the telegram byte stream
module diag_telegram_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic tx_start_i,
    input wire logic tx_ready_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_last_o,
    input wire logic tx_busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] beat_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // index of the byte now on offer within a frame
    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_busy_o) begin
            beat_r <= 5'h00;
        end else if (tx_valid_o && tx_ready_i) begin
            beat_r <= beat_r + 5'h01;
        end
    end
    a_ack_one_pulse: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=>
        wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse one cycle after request");
    a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_start_to_valid: assert property ((tx_start_i && !tx_busy_o) |=>
        tx_busy_o ##1 tx_valid_o)
        else $error("frame start not followed by first byte");
    a_valid_holds: assert property ((tx_valid_o && !tx_ready_i) |=>
        tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
        else $error("offered byte changed before acceptance");
    a_gap_after_beat: assert property ((tx_valid_o && tx_ready_i && !tx_last_o) |=>
        !tx_valid_o ##1 tx_valid_o)
        else $error("no single idle cycle between bytes");
    a_last_ends_busy: assert property ((tx_valid_o && tx_ready_i && tx_last_o) |=>
        !tx_busy_o && !tx_valid_o)
        else $error("busy after final byte");
    a_last_at_end: assert property (tx_valid_o |-> (tx_last_o == (beat_r == 5'h1c)))
        else $error("last flag not on byte 28");
    a_fixed_zero: assert property ((tx_valid_o && (beat_r == 5'h02 || beat_r == 5'h08)) |->
        tx_data_o == 8'h00)
        else $error("reserved or fixed byte not zero");
    a_id_header: assert property ((tx_valid_o && beat_r == 5'h06) |-> tx_data_o == 8'h43)
        else $error("identifier part header wrong");
    a_dev_length: assert property ((tx_valid_o && beat_r == 5'h09) |-> tx_data_o == 8'h14)
        else $error("device part length wrong");
    a_slot_group: assert property ((tx_valid_o && beat_r == 5'h07) |->
        tx_data_o[0] == (tx_data_o[4] | tx_data_o[5]) && tx_data_o[7:6] == 2'h0 &&
        tx_data_o[3:1] == 3'h0)
        else $error("slot byte group or fixed bits wrong");
    a_vendor_high: assert property ((tx_valid_o && beat_r == 5'h04) |->
        tx_data_o == diag_telegram_pkg::VENDOR_CODE[15:8])
        else $error("vendor code high byte not first");
endmodule : diag_telegram_checker
bind diag_telegram diag_telegram_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .tx_start_i(tx_start_i),
    .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_last_o(tx_last_o), .tx_busy_o(tx_busy_o));
`default_nettype wire

// *** bench/diag_sink.sv ***
`default_nettype none
// byte sink in the place of the fieldbus master, prompt or slow
module diag_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic clr_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic [4:0] count_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cap [0:28];
    logic [1:0] pace_r;
    // ready every cycle, or one cycle in four when slow
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pace_r <= 2'h0;
            tx_ready_o <= 1'b0;
        end else begin
            pace_r <= pace_r + 2'h1;
            tx_ready_o <= !slow_i || (pace_r == 2'h3);
        end
    end
    // store the first 29 bytes in arrival order; later bytes are accepted but not stored
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            count_o <= 5'h00;
        end else if (tx_valid_i && tx_ready_o && count_o < 5'h1d) begin
            cap[count_o] <= tx_data_i;
            count_o <= count_o + 5'h01;
        end
    end
endmodule : diag_sink
`default_nettype wire

// *** bench/diag_telegram_test.sv ***
`default_nettype none
// frames under all-clear, all-set and random status, checked byte by byte and over the register bus
module test_diag_telegram;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
    logic [7:0] wb_adr = 8'h00, tx_data, wadr;
    logic [31:0] wb_dat = 32'h0, wb_q, q, r0, r1;
    logic [10:0] st = 11'h0;
    logic [63:0] sf = 64'h0;
    logic [1:0] w1;
    logic tx_start = 1'b0, slow = 1'b0, clr = 1'b0, rdy, tx_valid, tx_last, tx_busy;
    logic [4:0] cnt;
    int mismatches = 0, num_checks = 0, seed = 37918;
    diag_telegram dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_q),
        .wb_ack_o(wb_ack), .unreachable_i(st[0]), .not_ready_i(st[1]), .cfg_fault_i(st[2]),
        .unsupported_fn_i(st[3]), .prm_fault_i(st[4]), .deactivated_i(st[5]),
        .monitor_active_i(st[6]), .foreign_access_i(st[7]), .programming_device_i(st[8]),
        .safety_slot_diag_i(st[9]), .std_slot_diag_i(st[10]), .slave_fault_i(sf),
        .tx_start_i(tx_start), .tx_ready_i(rdy), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
        .tx_last_o(tx_last), .tx_busy_o(tx_busy));
    diag_sink sink_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .clr_i(clr),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(rdy), .count_o(cnt));
    // expected telegram byte for the present status
    function automatic logic [7:0] exp_byte(input int i);
        case (i)
            0: return {st[7] | st[8], st[4], 1'b0, st[3], |sf, st[2:0]};
            1: return {st[5], 3'h0, st[6], 1'b0, w1[1], w1[0] | st[4]};
            3: return (wadr > 8'h7e) ? 8'hff : wadr;
            4: return diag_telegram_pkg::VENDOR_CODE[15:8];
            5: return diag_telegram_pkg::VENDOR_CODE[7:0];
            6: return 8'h43;
            7: return {2'h0, st[10:9], 3'h0, st[10] | st[9]};
            9: return 8'h14;
            default: return (i >= 21) ? sf[8 * (i - 21) +: 8] : 8'h00;
        endcase
    endfunction : exp_byte
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one classic wishbone cycle, released only after ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        q = wb_q;
        if (n == 50) mismatches++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb
    // one frame; slow frames also hold start into the busy phase
    task automatic frame(input logic s);
        int n;
        @(posedge clk_i);
        slow <= s;
        clr <= 1'b1;
        tx_start <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        tx_start <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (n == 3) tx_start <= 1'b0;
        end while (tx_busy !== 1'b0 && n < 400);
        if (n == 400) mismatches++;
    endtask : frame
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, diag_telegram_pkg::REG_STAT1, 32'h0);
        check(q, 32'h1);
        wb(1'b0, diag_telegram_pkg::REG_MASTER, 32'h0);
        check(q, 32'hff);
        wb(1'b0, 8'h40, 32'h0);
        check(q, 32'h0);
        for (int f = 0; f < 6; f++) begin
            r0 = $random(seed);
            r1 = $random(seed);
            @(posedge clk_i);
            st <= (f == 0) ? 11'h0 : (f == 1) ? 11'h7ff : r0[10:0];
            sf <= (f == 0) ? 64'h0 : {r0, r1};
            wadr = (f == 0) ? 8'h7e : (f == 1) ? 8'h7f : r1[7:0];
            w1 = r1[9:8];
            wb(1'b1, diag_telegram_pkg::REG_STAT1, {30'h0, w1});
            wb(1'b1, diag_telegram_pkg::REG_MASTER, {24'h0, wadr});
            wb(1'b1, diag_telegram_pkg::REG_STAT0, 32'hffffffff);
            frame(f[0]);
            check({27'h0, cnt}, 32'h1d);
            for (int i = 0; i < 29; i++) begin
                check({24'h0, sink_u.cap[i]}, {24'h0, exp_byte(i)});
            end
            wb(1'b0, diag_telegram_pkg::REG_STAT0, 32'h0);
            check(q, {24'h0, exp_byte(0)});
            wb(1'b0, diag_telegram_pkg::REG_SLOT, 32'h0);
            check(q, {24'h0, exp_byte(7)});
            wb(1'b0, diag_telegram_pkg::REG_FAULT_A, 32'h0);
            check(q, sf[31:0]);
        end
        tally_and_finish();
    end
endmodule : test_diag_telegram
`default_nettype wire
